// ### inc/runtime_mon_pkg.sv
// constants and register indices for the runtime counter and
// fault log block
// assumes a 100 MHz core clock and 16-bit keypad parameter words
package runtime_mon_pkg;

  // --------------------------------------------------------------
  // parameter indices (keypad parameter numbers)
  // --------------------------------------------------------------
  localparam logic [9:0] IDX_ENC_COUNT = 10'd39;
  localparam logic [9:0] IDX_HRS_POWERED = 10'd42;
  localparam logic [9:0] IDX_HRS_ENABLED = 10'd43;
  localparam logic [9:0] IDX_ENERGY = 10'd44;
  localparam logic [9:0] IDX_FAN_HRS = 10'd45;
  localparam logic [9:0] IDX_ALARM = 10'd48;
  localparam logic [9:0] IDX_FAULT = 10'd49;
  localparam logic [9:0] IDX_HIST_BASE = 10'd50; // 4 words per entry
  localparam logic [9:0] IDX_HIST_LAST = 10'd89;
  localparam logic [9:0] IDX_SNAP_CURRENT = 10'd90;
  localparam logic [9:0] IDX_SNAP_BUS_V = 10'd91;
  localparam logic [9:0] IDX_SNAP_SPEED = 10'd92;
  localparam logic [9:0] IDX_SNAP_REF = 10'd93;
  localparam logic [9:0] IDX_SNAP_FREQ = 10'd94;
  localparam logic [9:0] IDX_SNAP_MOT_V = 10'd95;

  // --------------------------------------------------------------
  // limits and selector codes
  // --------------------------------------------------------------
  localparam logic [15:0] ENC_MAX = 16'h9C40; // 40000
  localparam logic [15:0] ENABLED_MAX = 16'hFFFF; // 6553.5 h in 0.1 h
  localparam logic [15:0] CODE_MAX = 16'h03E7; // 999
  localparam logic [7:0] AO_SEL_ENCODER = 8'h31; // code 49
  localparam logic [2:0] CLR_FAN = 3'h2;
  localparam logic [2:0] CLR_ENABLED = 3'h3;
  localparam logic [2:0] CLR_ENERGY = 3'h4;
  localparam int HIST_DEPTH = 10;
  localparam int HIST_WORDS = 4;

  // --------------------------------------------------------------
  // time base
  // --------------------------------------------------------------
  localparam int CLK_HZ = 100_000_000;
  localparam int SECONDS_PER_HOUR = 3600;
  localparam int SECONDS_PER_TENTH_HOUR = 360;
  // one hour and one tenth hour in core cycles, exceed 32 bits
  localparam longint CYC_PER_HOUR = longint'(CLK_HZ) * SECONDS_PER_HOUR;
  localparam longint CYC_PER_TENTH =
    longint'(CLK_HZ) * SECONDS_PER_TENTH_HOUR;
  // energy: power in 0.1 kW per cycle; 1 kWh = 10 * cycles per hour
  localparam longint ENERGY_UNITS_PER_KWH = 64'd10 * CYC_PER_HOUR;
  localparam logic [15:0] RESET_WORD = 16'h0000;

endpackage

// ### src/hour_ticker.sv
// free running divider that pulses once every TICK_CYCLES while enabled
// assumes one core clock; count held when the gate is low
`timescale 1ns/100ps
`default_nettype none
module hour_ticker #(
  parameter longint TICK_CYCLES = 64'd360000000000
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic run_i,
  output logic tick_o
);
  import runtime_mon_pkg::*;

  logic [39:0] cnt_r; // cycles within the present interval

  // --------------------------------------------------------------
  // interval counter; partial time is kept while gated off
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      cnt_r <= '0;
      tick_o <= 1'b0;
    end else if (run_i) begin
      if (cnt_r == 40'(TICK_CYCLES - 1)) begin
        cnt_r <= '0;
        tick_o <= 1'b1;
      end else begin
        cnt_r <= cnt_r + 40'd1;
        tick_o <= 1'b0;
      end
    end else begin
      tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### src/energy_integrator.sv
// integrates output power over time and pulses once per kilowatt-hour
// assumes power arrives in 0.1 kW units, sampled every core cycle
`timescale 1ns/100ps
`default_nettype none
module energy_integrator #(
  parameter longint UNITS_PER_KWH = 64'd3600000000000
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [15:0] power_i,
  output logic kwh_tick_o
);
  import runtime_mon_pkg::*;

  logic [47:0] acc_r; // running energy below one kWh
  logic [47:0] acc_nxt;

  // --------------------------------------------------------------
  // accumulator; remainder carried so no energy is dropped
  // --------------------------------------------------------------
  always_comb begin
    acc_nxt = acc_r + {32'h0000_0000, power_i};
  end

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      acc_r <= '0;
      kwh_tick_o <= 1'b0;
    end else if (acc_nxt >= 48'(UNITS_PER_KWH)) begin
      acc_r <= acc_nxt - 48'(UNITS_PER_KWH); // R24
      kwh_tick_o <= 1'b1;
    end else begin
      acc_r <= acc_nxt;
      kwh_tick_o <= 1'b0;
    end
  end
endmodule
`default_nettype wire

// ### src/runtime_counters_fault_log.sv
// runtime counters, encoder pulse count and fault history for a drive
// assumes live drive quantities and clock/date come from same-clock
// logic; encoder phases and undervoltage are pins and are synchronised
//
// What this block does
// R1: encoder count up cw, down ccw, 0..40000
// R2: analog output selector 49 routes encoder count
// R3: powered hours counted, read-only 0..65535
// R4: undervoltage onset requests a nonvolatile save of the four runtime counters
// R5: enabled time in 0.1 h, wraps after 6553.5
// R6: selector value 3 clears enabled time
// R7: energy kWh counted, wraps after 65535
// R8: selector value 4 clears energy
// R9: fan hours counted, wraps after 65535
// R10: selector value 2 clears fan hours
// R11: present alarm and fault codes, 0..999
// R12: new fault shifts ten-entry history, newest first
// R13: day/month stamp shifts with entry
// R14: two-digit year shifts with entry
// R15: hour:minute time shifts with entry
// R16: latch output current at last fault
// R17: latch DC bus voltage at last fault
// R18: latch motor speed at last fault
// R19: latch speed reference at last fault
// R20: latch output frequency at last fault
// R21: latch motor voltage at last fault
// R22: fault near power-up may hold invalid data
// R23: whole fault record updates in one cycle
// R24: energy ticks when integrated power crosses 1 kWh
`timescale 1ns/100ps
`default_nettype none
module runtime_counters_fault_log #(
  parameter longint CYC_HOUR = runtime_mon_pkg::CYC_PER_HOUR,
  parameter longint CYC_TENTH = runtime_mon_pkg::CYC_PER_TENTH,
  parameter longint UNITS_KWH = runtime_mon_pkg::ENERGY_UNITS_PER_KWH
) (
  input wire logic core_clk_i,
  input wire logic nrst_i,
  // keypad parameter read port
  input wire logic [9:0] param_idx_i,
  output logic [15:0] param_data_o,
  // counter reset selector write
  input wire logic clr_wr_i,
  input wire logic [2:0] counter_reset_selector_i,
  // retained values restored at power-up
  input wire logic restore_i,
  input wire logic [15:0] restore_powered_i,
  input wire logic [15:0] restore_enabled_i,
  input wire logic [15:0] restore_energy_i,
  input wire logic [15:0] restore_fan_i,
  // nonvolatile save request, one pulse per undervoltage onset
  input wire logic undervolt_i,
  output logic nv_save_o,
  // drive state
  input wire logic drive_enabled_i,
  input wire logic fan_running_i,
  input wire logic [15:0] output_power_i,
  // encoder phases (pins)
  input wire logic enc_a_i,
  input wire logic enc_b_i,
  // analog output selectors and their source words
  input wire logic [7:0] analog_out_a_select_i,
  input wire logic [7:0] analog_out_b_select_i,
  input wire logic [15:0] ao_a_src_i,
  input wire logic [15:0] ao_b_src_i,
  output logic [15:0] ao_a_o,
  output logic [15:0] ao_b_o,
  // alarms, faults and calendar
  input wire logic [15:0] alarm_code_i,
  input wire logic [15:0] fault_code_i,
  input wire logic fault_event_i,
  input wire logic [15:0] date_daymonth_i,
  input wire logic [15:0] date_year_i,
  input wire logic [15:0] time_hhmm_i,
  // live quantities for the snapshot
  input wire logic [15:0] live_current_i,
  input wire logic [15:0] live_bus_voltage_i,
  input wire logic [15:0] live_speed_i,
  input wire logic [15:0] live_reference_i,
  input wire logic [15:0] live_frequency_i,
  input wire logic [15:0] live_motor_voltage_i
);
  import runtime_mon_pkg::*;

  // --------------------------------------------------------------
  // declarations
  // --------------------------------------------------------------
  logic [15:0] enc_count_r; // encoder pulse count
  logic [15:0] hrs_powered_r; // whole powered hours
  logic [15:0] hrs_enabled_r; // enabled time, tenths of hour
  logic [15:0] energy_r; // whole kWh
  logic [15:0] fan_hrs_r; // whole fan hours
  logic [15:0] alarm_r; // present alarm code
  logic [15:0] fault_r; // present fault code
  // history: [entry][0 code,1 day/month,2 year,3 time]
  logic [15:0] hist_r [HIST_DEPTH][HIST_WORDS];
  logic [15:0] snap_r [6]; // snapshot at most recent fault
  logic [2:0] enc_a_s_r, enc_b_s_r; // sync stages plus previous
  logic [1:0] uv_s_r; // undervoltage sync
  logic uv_prev_r;
  logic tick_powered, tick_enabled, tick_fan, tick_kwh;
  logic enc_step, enc_up;
  logic [9:0] hist_off;

  // clamp a code to its printed 0..999 range
  function automatic logic [15:0] clamp_code(input logic [15:0] c);
    clamp_code = (c > CODE_MAX) ? CODE_MAX : c;
  endfunction

  // --------------------------------------------------------------
  // time bases
  // --------------------------------------------------------------
  hour_ticker #(.TICK_CYCLES(CYC_HOUR)) u_pwr_tick (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(1'b1),
    .tick_o(tick_powered)
  );

  hour_ticker #(.TICK_CYCLES(CYC_TENTH)) u_en_tick (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(drive_enabled_i),
    .tick_o(tick_enabled)
  );

  hour_ticker #(.TICK_CYCLES(CYC_HOUR)) u_fan_tick (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .run_i(fan_running_i),
    .tick_o(tick_fan)
  );

  energy_integrator #(.UNITS_PER_KWH(UNITS_KWH)) u_energy (
    .core_clk_i(core_clk_i),
    .nrst_i(nrst_i),
    .power_i(output_power_i),
    .kwh_tick_o(tick_kwh)
  );

  // --------------------------------------------------------------
  // pin synchronisers; stage 0 is read only by stage 1
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc_a_s_r <= '0;
      enc_b_s_r <= '0;
      uv_s_r <= '0;
      uv_prev_r <= 1'b0;
    end else begin
      enc_a_s_r <= {enc_a_s_r[1:0], enc_a_i};
      enc_b_s_r <= {enc_b_s_r[1:0], enc_b_i};
      uv_s_r <= {uv_s_r[0], undervolt_i};
      uv_prev_r <= uv_s_r[1];
    end
  end

  // count on rising edge of phase a; b high means counterclockwise
  assign enc_step = enc_a_s_r[1] & ~enc_a_s_r[2];
  assign enc_up = ~enc_b_s_r[1];

  // --------------------------------------------------------------
  // encoder pulse count, saturating at both ends
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      enc_count_r <= RESET_WORD;
    end else if (enc_step) begin
      if (enc_up && enc_count_r < ENC_MAX) begin
        enc_count_r <= enc_count_r + 16'h0001; // R1
      end else if (!enc_up && enc_count_r != 16'h0000) begin
        enc_count_r <= enc_count_r - 16'h0001; // R1
      end
    end
  end

  // --------------------------------------------------------------
  // analog output routing, registered
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ao_a_o <= RESET_WORD;
      ao_b_o <= RESET_WORD;
    end else begin
      ao_a_o <= (analog_out_a_select_i == AO_SEL_ENCODER) ?
                enc_count_r : ao_a_src_i; // R2
      ao_b_o <= (analog_out_b_select_i == AO_SEL_ENCODER) ?
                enc_count_r : ao_b_src_i; // R2
    end
  end

  // --------------------------------------------------------------
  // powered hours; restore wins since it happens only at start-up
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrs_powered_r <= RESET_WORD;
    end else if (restore_i) begin
      hrs_powered_r <= restore_powered_i;
    end else if (tick_powered) begin
      hrs_powered_r <= hrs_powered_r + 16'h0001; // R3
    end
  end

  // --------------------------------------------------------------
  // enabled time in tenths; 16-bit wrap gives 6553.5 -> 0
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hrs_enabled_r <= RESET_WORD;
    end else if (restore_i) begin
      hrs_enabled_r <= restore_enabled_i;
    end else if (clr_wr_i && counter_reset_selector_i == CLR_ENABLED) begin
      hrs_enabled_r <= RESET_WORD; // R6
    end else if (tick_enabled) begin
      hrs_enabled_r <= (hrs_enabled_r == ENABLED_MAX) ? RESET_WORD :
                       hrs_enabled_r + 16'h0001; // R5
    end
  end

  // --------------------------------------------------------------
  // energy counter, wraps after 65535 kWh
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      energy_r <= RESET_WORD;
    end else if (restore_i) begin
      energy_r <= restore_energy_i;
    end else if (clr_wr_i && counter_reset_selector_i == CLR_ENERGY) begin
      energy_r <= RESET_WORD; // R8
    end else if (tick_kwh) begin
      energy_r <= energy_r + 16'h0001; // R7 R24
    end
  end

  // --------------------------------------------------------------
  // fan hours, wraps after 65535
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      fan_hrs_r <= RESET_WORD;
    end else if (restore_i) begin
      fan_hrs_r <= restore_fan_i;
    end else if (clr_wr_i && counter_reset_selector_i == CLR_FAN) begin
      fan_hrs_r <= RESET_WORD; // R10
    end else if (tick_fan) begin
      fan_hrs_r <= fan_hrs_r + 16'h0001; // R9
    end
  end

  // --------------------------------------------------------------
  // save request on undervoltage onset; the store picks up all four
  // counters from the parameter port in the same window
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      nv_save_o <= 1'b0;
    end else begin
      nv_save_o <= uv_s_r[1] & ~uv_prev_r; // R4
    end
  end

  // --------------------------------------------------------------
  // present alarm and fault codes
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      alarm_r <= RESET_WORD;
      fault_r <= RESET_WORD;
    end else begin
      alarm_r <= clamp_code(alarm_code_i); // R11
      fault_r <= clamp_code(fault_code_i); // R11
    end
  end

  // --------------------------------------------------------------
  // fault history shift; stamps travel with their code.
  // no qualification is done for a fault at power-up: its stamps
  // are whatever the calendar shows then, possibly not yet valid
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int e = 0; e < HIST_DEPTH; e++) begin
        for (int w = 0; w < HIST_WORDS; w++) begin
          hist_r[e][w] <= RESET_WORD;
        end
      end
    end else if (fault_event_i) begin // R22 R23
      for (int e = HIST_DEPTH - 1; e > 0; e--) begin
        for (int w = 0; w < HIST_WORDS; w++) begin
          hist_r[e][w] <= hist_r[e-1][w]; // R12 R13 R14 R15
        end
      end
      hist_r[0][0] <= clamp_code(fault_code_i); // R12
      hist_r[0][1] <= date_daymonth_i; // R13
      hist_r[0][2] <= date_year_i; // R14
      hist_r[0][3] <= time_hhmm_i; // R15
    end
  end

  // --------------------------------------------------------------
  // snapshot of drive quantities, same cycle as the history shift
  // --------------------------------------------------------------
  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      for (int i = 0; i < 6; i++) begin
        snap_r[i] <= RESET_WORD;
      end
    end else if (fault_event_i) begin // R23
      snap_r[0] <= live_current_i; // R16
      snap_r[1] <= live_bus_voltage_i; // R17
      snap_r[2] <= live_speed_i; // R18
      snap_r[3] <= live_reference_i; // R19
      snap_r[4] <= live_frequency_i; // R20
      snap_r[5] <= live_motor_voltage_i; // R21
    end
  end

  // --------------------------------------------------------------
  // parameter read mux, registered; unknown indices read zero
  // --------------------------------------------------------------
  assign hist_off = param_idx_i - IDX_HIST_BASE;

  always_ff @(posedge core_clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      param_data_o <= RESET_WORD;
    end else if (param_idx_i >= IDX_HIST_BASE &&
                 param_idx_i <= IDX_HIST_LAST) begin
      param_data_o <= hist_r[hist_off[5:2]][hist_off[1:0]];
    end else begin
      unique case (param_idx_i)
        IDX_ENC_COUNT: param_data_o <= enc_count_r;
        IDX_HRS_POWERED: param_data_o <= hrs_powered_r;
        IDX_HRS_ENABLED: param_data_o <= hrs_enabled_r;
        IDX_ENERGY: param_data_o <= energy_r;
        IDX_FAN_HRS: param_data_o <= fan_hrs_r;
        IDX_ALARM: param_data_o <= alarm_r;
        IDX_FAULT: param_data_o <= fault_r;
        IDX_SNAP_CURRENT: param_data_o <= snap_r[0];
        IDX_SNAP_BUS_V: param_data_o <= snap_r[1];
        IDX_SNAP_SPEED: param_data_o <= snap_r[2];
        IDX_SNAP_REF: param_data_o <= snap_r[3];
        IDX_SNAP_FREQ: param_data_o <= snap_r[4];
        IDX_SNAP_MOT_V: param_data_o <= snap_r[5];
        default: param_data_o <= RESET_WORD;
      endcase
    end
  end
endmodule
`default_nettype wire

// ### testbench/runtime_counters_fault_log_properties.sv
// assertions for the runtime counter and fault log block
// sees only the top module's ports; bound below the module
`timescale 1ns/100ps
`default_nettype none
module runtime_counters_fault_log_properties
  import runtime_mon_pkg::*;
(
  input wire logic core_clk_i,
  input wire logic nrst_i,
  input wire logic [9:0] param_idx_i,
  input wire logic [15:0] param_data_o,
  input wire logic clr_wr_i,
  input wire logic [2:0] counter_reset_selector_i,
  input wire logic restore_i,
  input wire logic undervolt_i,
  input wire logic nv_save_o,
  input wire logic [7:0] analog_out_a_select_i,
  input wire logic [15:0] ao_a_src_i,
  input wire logic [15:0] ao_a_o,
  input wire logic [15:0] alarm_code_i,
  input wire logic [15:0] fault_code_i,
  input wire logic fault_event_i,
  input wire logic [15:0] time_hhmm_i,
  input wire logic [15:0] live_current_i
);
  // ------------------------------------------------------------
  // one clock domain, so one default clocking
  // ------------------------------------------------------------
  default clocking cb @(posedge core_clk_i);
  endclocking
  default disable iff (!nrst_i);

  // sync chain plus edge detect bounds the save delay
  save_follows_a: assert property (
    $rose(undervolt_i) |-> ##[1:4] nv_save_o)
    else $error("no save pulse after undervoltage");
  save_single_a: assert property (
    nv_save_o |=> !nv_save_o)
    else $error("save pulse longer than one cycle");
  // read path adds one cycle to the registered code
  alarm_read_a: assert property (
    param_idx_i == IDX_ALARM |=> param_data_o ==
      ($past(alarm_code_i, 2) > CODE_MAX ? CODE_MAX :
       $past(alarm_code_i, 2)))
    else $error("alarm code read mismatch");
  fault_code_a: assert property (
    fault_event_i ##1 param_idx_i == IDX_HIST_BASE |=> param_data_o ==
      ($past(fault_code_i, 2) > CODE_MAX ? CODE_MAX :
       $past(fault_code_i, 2)))
    else $error("newest history code wrong");
  snap_current_a: assert property (
    fault_event_i ##1 param_idx_i == IDX_SNAP_CURRENT |=>
      param_data_o == $past(live_current_i, 2))
    else $error("current snapshot wrong");
  stamp_time_a: assert property (
    fault_event_i ##1 param_idx_i == IDX_HIST_BASE + 10'h003 |=>
      param_data_o == $past(time_hhmm_i, 2))
    else $error("newest time stamp wrong");
  enc_route_a: assert property (
    analog_out_a_select_i == AO_SEL_ENCODER &&
      param_idx_i == IDX_ENC_COUNT |=> ao_a_o == param_data_o)
    else $error("analog output not showing encoder count");
  ao_pass_a: assert property (
    analog_out_a_select_i != AO_SEL_ENCODER |=>
      ao_a_o == $past(ao_a_src_i))
    else $error("analog output source wrong");
  enc_range_a: assert property (
    param_idx_i == IDX_ENC_COUNT |=> param_data_o <= ENC_MAX)
    else $error("encoder count above ceiling");
  clear_enabled_a: assert property (
    clr_wr_i && !restore_i && counter_reset_selector_i == CLR_ENABLED
      ##1 param_idx_i == IDX_HRS_ENABLED |=> param_data_o == RESET_WORD)
    else $error("enabled time not cleared");

  // main scenarios
  cover property (fault_event_i ##1 fault_event_i);
  cover property (nv_save_o);
  cover property (clr_wr_i && counter_reset_selector_i == CLR_FAN);
endmodule

bind runtime_counters_fault_log runtime_counters_fault_log_properties
  i_runtime_counters_fault_log_properties (.*);
`default_nettype wire

// ### testbench/tb_top.sv
// self-checking bench for the runtime counter and fault log block
// drives every input at the falling edge; short tick parameters
`timescale 1ns/100ps
`default_nettype none
module tb_top;
  import runtime_mon_pkg::*;
  localparam int HOUR = 20;
  localparam int TENTH = 5;
  localparam int KWH = 100;
  logic core_clk_i = 1'b0, nrst_i = 1'b0, nv_save_o;
  logic clr_wr_i = 1'b0, restore_i = 1'b0, undervolt_i = 1'b0;
  logic drive_enabled_i = 1'b0, fan_running_i = 1'b0;
  logic fault_event_i = 1'b0, enc_a_i = 1'b0, enc_b_i = 1'b0;
  logic [9:0] param_idx_i = 10'h000;
  logic [2:0] counter_reset_selector_i = 3'h0;
  logic [7:0] analog_out_a_select_i = 8'h00;
  logic [7:0] analog_out_b_select_i = 8'h00;
  logic [15:0] param_data_o, ao_a_o, ao_b_o, output_power_i;
  logic [15:0] restore_powered_i, restore_enabled_i, restore_energy_i;
  logic [15:0] restore_fan_i, ao_a_src_i, ao_b_src_i, alarm_code_i;
  logic [15:0] fault_code_i, date_daymonth_i, date_year_i, time_hhmm_i;
  logic [15:0] live_current_i, live_bus_voltage_i, live_speed_i;
  logic [15:0] live_reference_i, live_frequency_i, live_motor_voltage_i;
  int n_mismatch = 0, tests_run = 0;

  runtime_counters_fault_log #(.CYC_HOUR(HOUR), .CYC_TENTH(TENTH),
    .UNITS_KWH(KWH)) i_runtime_counters_fault_log (.*);

  // 100 MHz core clock
  always #5 core_clk_i = ~core_clk_i;

  // ------------------------------------------------------------
  // helpers
  // ------------------------------------------------------------
  task automatic chk(string what, logic [15:0] exp, logic [15:0] got);
    tests_run++;
    if (got !== exp) begin
      n_mismatch++;
      $display("FAIL %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic cycles(int n);
    repeat (n) @(negedge core_clk_i);
  endtask
  // index taken at one edge, data sampled a cycle later
  task automatic rdchk(string what, logic [9:0] idx, logic [15:0] exp);
    @(negedge core_clk_i);
    param_idx_i = idx;
    @(negedge core_clk_i);
    chk(what, exp, param_data_o);
  endtask
  // record word w of fault i: code, day/month, year, time, snapshot
  function automatic logic [15:0] rec(int i, int w);
    case (w)
      0: rec = 16'(100 + i);
      1: rec = 16'h0100 + 16'(i);
      2: rec = 16'(i);
      3: rec = 16'h0900 + 16'(i);
      default: rec = 16'(w * 4096 + i);
    endcase
  endfunction
  task automatic set_rec(int i);
    fault_code_i = rec(i, 0);
    date_daymonth_i = rec(i, 1);
    date_year_i = rec(i, 2);
    time_hhmm_i = rec(i, 3);
    live_current_i = rec(i, 4);
    live_bus_voltage_i = rec(i, 5);
    live_speed_i = rec(i, 6);
    live_reference_i = rec(i, 7);
    live_frequency_i = rec(i, 8);
    live_motor_voltage_i = rec(i, 9);
  endtask
  // gates stay open an exact count so timer phase does not matter
  task automatic t_run;
    @(negedge core_clk_i);
    drive_enabled_i = 1'b1;
    fan_running_i = 1'b1;
    output_power_i = 16'h000A;
    for (int c = 1; c <= HOUR; c++) begin
      @(negedge core_clk_i);
      if (c == TENTH) drive_enabled_i = 1'b0;
      if (c == KWH / 10) output_power_i = 16'h0000;
    end
    fan_running_i = 1'b0;
  endtask
  task automatic clr(logic [2:0] sel, logic [9:0] idx, logic [15:0] exp);
    @(negedge core_clk_i);
    clr_wr_i = 1'b1;
    counter_reset_selector_i = sel;
    @(negedge core_clk_i);
    clr_wr_i = 1'b0;
    param_idx_i = idx;
    @(negedge core_clk_i);
    chk("counter after clear", exp, param_data_o);
  endtask
  // B is settled well before A rises; B low counts up
  task automatic enc_step(logic ccw);
    enc_b_i = ccw;
    cycles(4);
    enc_a_i = 1'b1;
    cycles(4);
    enc_a_i = 1'b0;
  endtask

  // ------------------------------------------------------------
  // scenarios
  // ------------------------------------------------------------
  task automatic t_reset;
    logic [9:0] idx [7] = '{IDX_HRS_POWERED, IDX_ENC_COUNT, IDX_ENERGY,
      IDX_HRS_ENABLED, IDX_FAN_HRS, IDX_HIST_BASE, 10'h064};
    for (int j = 0; j < 7; j++) rdchk("reset", idx[j], 16'h0000);
  endtask
  task automatic t_powered;
    rdchk("powered start", IDX_HRS_POWERED, 16'h0000);
    cycles(HOUR - 2);
    rdchk("powered step", IDX_HRS_POWERED, 16'h0001);
  endtask
  task automatic t_counters;
    {restore_enabled_i, restore_energy_i, restore_fan_i} = '1;
    @(negedge core_clk_i);
    restore_i = 1'b1;
    @(negedge core_clk_i);
    restore_i = 1'b0;
    rdchk("restored enabled", IDX_HRS_ENABLED, 16'hFFFF);
    t_run();
    rdchk("enabled wrap", IDX_HRS_ENABLED, 16'h0000);
    rdchk("energy wrap", IDX_ENERGY, 16'h0000);
    rdchk("fan wrap", IDX_FAN_HRS, 16'h0000);
    t_run();
    clr(3'h5, IDX_HRS_ENABLED, 16'h0001);
    clr(CLR_FAN, IDX_FAN_HRS, 16'h0000);
    rdchk("energy kept", IDX_ENERGY, 16'h0001);
    clr(CLR_ENABLED, IDX_HRS_ENABLED, 16'h0000);
    clr(CLR_ENERGY, IDX_ENERGY, 16'h0000);
  endtask
  task automatic t_save;
    int n;
    n = 0;
    undervolt_i = 1'b1;
    repeat (10) begin
      @(negedge core_clk_i);
      if (nv_save_o === 1'b1) n++;
    end
    chk("save pulses", 16'h0001, 16'(n));
    undervolt_i = 1'b0;
  endtask
  task automatic t_encoder;
    analog_out_a_select_i = AO_SEL_ENCODER;
    ao_b_src_i = 16'h0ABC;
    repeat (2) enc_step(1'b1);
    rdchk("count at floor", IDX_ENC_COUNT, 16'h0000);
    repeat (3) enc_step(1'b0);
    enc_step(1'b1);
    rdchk("count", IDX_ENC_COUNT, 16'h0002);
    chk("ao a", 16'h0002, ao_a_o);
    chk("ao b", 16'h0ABC, ao_b_o);
    analog_out_a_select_i = 8'h00;
    analog_out_b_select_i = AO_SEL_ENCODER;
    ao_a_src_i = 16'h1234;
    cycles(3);
    chk("ao a", 16'h1234, ao_a_o);
    chk("ao b", 16'h0002, ao_b_o);
  endtask
  task automatic t_codes;
    alarm_code_i = 16'h03E6;
    fault_code_i = 16'h03E8;
    rdchk("alarm code", IDX_ALARM, 16'h03E6);
    rdchk("fault code", IDX_FAULT, CODE_MAX);
  endtask
  // ten faults back to back, then three each read at once
  task automatic t_faults;
    logic [9:0] a;
    for (int i = 0; i < 13; i++) begin
      @(negedge core_clk_i);
      set_rec(i);
      fault_event_i = 1'b1;
      if (i >= 10) begin
        @(negedge core_clk_i);
        fault_event_i = 1'b0;
        a = i == 10 ? IDX_HIST_BASE : i == 11 ? IDX_SNAP_CURRENT : 10'h035;
        param_idx_i = a;
        @(negedge core_clk_i);
        chk("at fault", rec(i, i == 10 ? 0 : 15 - i), param_data_o);
      end
    end
    for (int k = 0; k < HIST_DEPTH; k++) begin
      for (int w = 0; w < HIST_WORDS; w++) begin
        a = IDX_HIST_BASE + 10'(HIST_WORDS * k + w);
        rdchk("history word", a, rec(12 - k, w));
      end
    end
    a = IDX_SNAP_CURRENT - 10'h004;
    for (int s = 4; s < 10; s++)
      rdchk("snap", a + 10'(s), rec(12, s));
  endtask

  task automatic wrap_up;
    $display("mismatches %0d comparisons %0d", n_mismatch, tests_run);
    if (n_mismatch == 0 && tests_run > 0) $display("ALL CHECKS OK");
    else $display("CHECKS NOT OK");
    $finish;
  endtask

  initial begin
    {restore_powered_i, restore_enabled_i, restore_energy_i} = '0;
    {restore_fan_i, output_power_i, ao_a_src_i, ao_b_src_i} = '0;
    alarm_code_i = 16'h0000;
    set_rec(0);
    cycles(12);
    nrst_i = 1'b1;
    t_reset();
    t_powered();
    t_counters();
    t_save();
    t_encoder();
    t_codes();
    t_faults();
    wrap_up();
  end
endmodule
`default_nettype wire
